// *** rtl/pmt_defines.svh ***
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// Command codes
`define PMT_CMD_CLEAR_FAULTS 8'h03
`define PMT_CMD_READ_POUT    8'h96
`define PMT_CMD_FINE_IOUT    8'hbb
`define PMT_CMD_SENSE_VOLT   8'hfa
`define PMT_CMD_VIN_MAX      8'hde
`define PMT_CMD_VIN_LOW      8'hfc
`define PMT_CMD_VOUT_PEAK    8'hdd
`define PMT_CMD_VOUT_MIN     8'hfb
`define PMT_CMD_IOUT_PEAK    8'hd7
`define PMT_CMD_IOUT_MIN     8'hd8
`define PMT_CMD_TEMP_PEAK    8'hdf
`define PMT_CMD_TEMP_MIN     8'hfd
`define PMT_CMD_LOG_STORE    8'hea
`define PMT_CMD_LOG_RESTORE  8'heb
`define PMT_CMD_LOG_CLEAR    8'hec
`define PMT_CMD_LOG_STATUS   8'hed
`define PMT_CMD_LOG_READ     8'hee

// Page that addresses every channel at once
`define PMT_PAGE_ALL 8'hff

// Peak and minimum load values
`define PMT_VIN_PEAK_INIT  16'h7c00
`define PMT_VIN_MIN_INIT   16'h7bff
`define PMT_VOUT_PEAK_INIT 16'hf800
`define PMT_VOUT_MIN_INIT  16'hffff
`define PMT_IOUT_PEAK_INIT 16'h7c00
`define PMT_IOUT_MIN_INIT  16'h7bff
`define PMT_TEMP_PEAK_INIT 16'h7c00
`define PMT_TEMP_MIN_INIT  16'h7bff

// Fault-log status byte
`define PMT_STAT_RAM_BIT 1
`define PMT_STAT_EEP_BIT 0

// Fine current limits, in 2.5 mA counts
`define PMT_FINE_MAX 16'h7fff
`define PMT_FINE_MIN 16'h8000

`define PMT_LOG_BYTES 255
`define PMT_CHANNELS  2

`endif

// *** rtl/pmt_pkg.sv ***
package pmt_pkg;

  typedef enum logic [4:0] {
    PMT_MK_VIN  = 5'b00001,
    PMT_MK_VOUT = 5'b00010,
    PMT_MK_IOUT = 5'b00100,
    PMT_MK_TEMP = 5'b01000,
    PMT_MK_POUT = 5'b10000
  } pmt_meas_e;

  typedef struct packed {
    logic [15:0] peak;
    logic [15:0] low;
  } pmt_trk_s;

  typedef struct packed {
    logic [1:0][15:0] pout;
    logic [1:0][15:0] fine;
    logic [1:0][15:0] sense;
    logic [1:0]       on_prev;
    logic             stat_ram;
    logic             stat_eep;
    logic [7:0]       log_idx;
    logic             rsp_valid;
    logic [15:0]      rsp_data;
    logic             rsp_err;
    logic             store_req;
    logic             restore_req;
    logic             clear_req;
  } pmt_main_s;

endpackage

// *** rtl/pmt_extreme_track.sv ***
`timescale 1ns/1ns
`include "pmt_defines.svh"

module pmt_extreme_track #(
  parameter bit          IS_L16    = 1'b0,
  parameter logic [15:0] PEAK_INIT = `PMT_IOUT_PEAK_INIT,
  parameter logic [15:0] MIN_INIT  = `PMT_IOUT_MIN_INIT
) (
  input  wire logic        sys_clk,      // System clock
  input  wire logic        rst_b,        // Sync reset, active low
  input  wire logic        clear,        // Reload both extremes
  input  wire logic        sample_valid, // New conversion
  input  wire logic [15:0] sample,       // Converted value
  output logic      [15:0] peak_reg,     // Largest since clear
  output logic      [15:0] min_reg       // Smallest since clear
);

  pmt_pkg::pmt_trk_s st_reg;
  pmt_pkg::pmt_trk_s st_next;

  // Linear-11 words are ordered by value, not by raw bits
  function automatic logic signed [47:0] key(input logic [15:0] v);
    logic signed [47:0] m;
    int                 sh;
    m  = 48'(signed'(v[10:0]));
    sh = int'(signed'(v[15:11])) + 16;
    if (IS_L16) begin
      key = 48'(v);
    end else begin
      key = m <<< sh;
    end
  endfunction

  // The output-voltage peak load value stands for 0.0, below any reading,
  // so the first sample after a clear always replaces it. A real reading
  // equal to that value is then also treated as empty.
  function automatic logic signed [47:0] pk_key(input logic [15:0] v);
    if (IS_L16 && v == PEAK_INIT) begin
      pk_key = -48'sd1;
    end else begin
      pk_key = key(v);
    end
  endfunction

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.peak = PEAK_INIT;
      st_next.low  = MIN_INIT;
    end else if (sample_valid) begin
      if (key(sample) > pk_key(st_reg.peak)) begin
        st_next.peak = sample;
      end
      if (key(sample) < key(st_reg.low)) begin
        st_next.low = sample;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg.peak <= PEAK_INIT;
      st_reg.low  <= MIN_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign peak_reg = st_reg.peak;
  assign min_reg  = st_reg.low;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  clear_reload_a: assert property (
    clear |=> peak_reg == PEAK_INIT && min_reg == MIN_INIT)
    else $error("extreme not reloaded after clear");
  peak_keep_a: assert property (
    !clear |=> key(peak_reg) >= pk_key($past(peak_reg)) &&
               key(min_reg) <= key($past(min_reg)))
    else $error("extreme moved the wrong way");
  peak_take_a: assert property (
    !clear && sample_valid |=> key(peak_reg) >= key($past(sample)) &&
                               key(min_reg) <= key($past(sample)))
    else $error("sample outside tracked extremes");

endmodule

// *** rtl/pmt_telemetry.sv ***
`timescale 1ns/1ns
`include "pmt_defines.svh"

// Summary of operation
// - Fine current is signed 16-bit, one count per 2.5 mA.
// - Fine current clamps at +/-81.92 A; beyond, use the normal read.
// - Sense voltage is raw magnitude from the last current conversion.
// - Sense count is unsigned; LSB depends on the current-monitor select.
// - Power read returns latest measured output power of the page.
// - Input-voltage peak loads 0x7C00 on reset, any clear, any turn-on.
// - Output-voltage peak loads 0xF800 on reset, page clear, turn-on.
// - Output-current peak loads 0x7C00 on reset, page clear, turn-on.
// - Temperature peak loads 0x7C00 on reset, page clear, turn-on.
// - Input-voltage minimum loads 0x7BFF on reset, any clear or turn-on.
// - Output-voltage minimum loads 0xFFFF on reset, page clear, turn-on.
// - Output-current minimum loads 0x7BFF on reset, page clear, turn-on.
// - Temperature minimum loads 0x7BFF on reset, page clear, turn-on.
// - Code 0xEA send-byte requests copy of log RAM to nonvolatile.
// - Code 0xEB send-byte requests restore of stored log into RAM.
// - Code 0xEC send-byte erases nonvolatile log and releases locks.
// - Code 0xEE returns log bytes in order; status byte at 0xED.
// - Status bit1 RAM locked, bit0 nonvolatile copy inhibited, rest zero.
// - Bit0 sets after a completed copy; only log clear resets it.

module pmt_telemetry #(
  parameter int LOG_BYTES = `PMT_LOG_BYTES
) (
  input  wire logic               sys_clk,          // 20 MHz clock
  input  wire logic               rst_b,            // Sync reset, low
  input  wire logic               cmd_valid,        // Command pulse
  input  wire logic        [7:0]  cmd_code,         // Command code
  input  wire logic        [7:0]  cmd_page,         // Current page
  input  wire logic               cmd_read,         // 1 read, 0 send
  input  wire logic               meas_valid,       // Conversion pulse
  input  wire logic        [4:0]  meas_kind,        // One-hot kind
  input  wire logic               meas_chan,        // Channel of value
  input  wire logic        [15:0] meas_value,       // Formatted value
  input  wire logic signed [19:0] meas_iout_fine,   // 2.5 mA counts
  input  wire logic signed [16:0] meas_sense,       // Raw sense count
  input  wire logic        [1:0]  chan_on,          // Channel enabled
  input  wire logic               log_eep_done,     // Copy completed
  input  wire logic               log_restore_done, // Restore done
  input  wire logic        [7:0]  log_byte,         // Byte at index
  output logic                    rsp_valid,        // Answer pulse
  output logic             [15:0] rsp_data,         // Answer data
  output logic                    rsp_err,          // Unknown command, or bad page on power/fine/sense read
  output logic                    log_store_req,    // Store pulse
  output logic                    log_restore_req,  // Restore pulse
  output logic                    log_clear_req,    // Erase pulse
  output logic             [7:0]  log_byte_idx      // Log read index
);

  if (LOG_BYTES < 2 || LOG_BYTES > 256) begin : g_chk
    $error("LOG_BYTES must lie in 2..256");
  end

  localparam logic [7:0] LAST_IDX = 8'(LOG_BYTES - 1);

  pmt_pkg::pmt_main_s st_reg;
  pmt_pkg::pmt_main_s st_next;

  logic             [1:0] on_rise;
  logic                   clr_cmd;
  logic                   send_cmd;
  logic             [1:0] clr_ch;
  logic                   clr_in;
  logic                   paged_ok;
  logic                   ch;
  pmt_pkg::pmt_meas_e     kind;
  logic                   smp_vin;
  logic             [1:0] smp_vout;
  logic             [1:0] smp_iout;
  logic             [1:0] smp_temp;
  logic            [15:0] vin_pk;
  logic            [15:0] vin_lo;
  logic       [1:0][15:0] vout_pk;
  logic       [1:0][15:0] vout_lo;
  logic       [1:0][15:0] iout_pk;
  logic       [1:0][15:0] iout_lo;
  logic       [1:0][15:0] temp_pk;
  logic       [1:0][15:0] temp_lo;

  function automatic logic [15:0] sat_fine(input logic signed [19:0] v);
    if (v > 20'sd32767) begin
      sat_fine = `PMT_FINE_MAX;
    end else if (v < -20'sd32768) begin
      sat_fine = `PMT_FINE_MIN;
    end else begin
      sat_fine = v[15:0];
    end
  endfunction

  // magnitude only; -65536 would not fit, so it saturates
  function automatic logic [15:0] abs_sense(input logic signed [16:0] v);
    logic [16:0] m;
    m = v[16] ? 17'(-v) : 17'(v);
    abs_sense = m[16] ? 16'hffff : m[15:0];
  endfunction

  assign send_cmd = cmd_valid && !cmd_read;
  assign kind     = pmt_pkg::pmt_meas_e'(meas_kind);
  assign on_rise  = chan_on & ~st_reg.on_prev;
  assign clr_cmd  = send_cmd && cmd_code == `PMT_CMD_CLEAR_FAULTS;
  assign paged_ok = cmd_page[7:1] == 7'h00;
  assign ch       = cmd_page[0];
  // input extremes clear on any page or any turn-on
  assign clr_in   = clr_cmd || (|on_rise);
  assign smp_vin  = meas_valid && kind == pmt_pkg::PMT_MK_VIN;

  pmt_extreme_track #(
    .IS_L16    (1'b0),
    .PEAK_INIT (`PMT_VIN_PEAK_INIT),
    .MIN_INIT  (`PMT_VIN_MIN_INIT)
  ) u_vin (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .clear        (clr_in),
    .sample_valid (smp_vin),
    .sample       (meas_value),
    .peak_reg     (vin_pk),
    .min_reg      (vin_lo)
  );

  for (genvar c = 0; c < `PMT_CHANNELS; c++) begin : g_ch
    // page clear, all-page clear or own turn-on
    assign clr_ch[c] = (clr_cmd && (cmd_page == 8'(c) ||
                       cmd_page == `PMT_PAGE_ALL)) || on_rise[c];
    assign smp_vout[c] = meas_valid && meas_chan == 1'(c) &&
                         kind == pmt_pkg::PMT_MK_VOUT;
    assign smp_iout[c] = meas_valid && meas_chan == 1'(c) &&
                         kind == pmt_pkg::PMT_MK_IOUT;
    assign smp_temp[c] = meas_valid && meas_chan == 1'(c) &&
                         kind == pmt_pkg::PMT_MK_TEMP;

    pmt_extreme_track #(
      .IS_L16    (1'b1),
      .PEAK_INIT (`PMT_VOUT_PEAK_INIT),
      .MIN_INIT  (`PMT_VOUT_MIN_INIT)
    ) u_vout (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .clear        (clr_ch[c]),
      .sample_valid (smp_vout[c]),
      .sample       (meas_value),
      .peak_reg     (vout_pk[c]),
      .min_reg      (vout_lo[c])
    );

    pmt_extreme_track #(
      .IS_L16    (1'b0),
      .PEAK_INIT (`PMT_IOUT_PEAK_INIT),
      .MIN_INIT  (`PMT_IOUT_MIN_INIT)
    ) u_iout (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .clear        (clr_ch[c]),
      .sample_valid (smp_iout[c]),
      .sample       (meas_value),
      .peak_reg     (iout_pk[c]),
      .min_reg      (iout_lo[c])
    );

    pmt_extreme_track #(
      .IS_L16    (1'b0),
      .PEAK_INIT (`PMT_TEMP_PEAK_INIT),
      .MIN_INIT  (`PMT_TEMP_MIN_INIT)
    ) u_temp (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .clear        (clr_ch[c]),
      .sample_valid (smp_temp[c]),
      .sample       (meas_value),
      .peak_reg     (temp_pk[c]),
      .min_reg      (temp_lo[c])
    );
  end

  always_comb begin
    st_next             = st_reg;
    st_next.rsp_valid   = 1'b0;
    st_next.rsp_err     = 1'b0;
    st_next.store_req   = 1'b0;
    st_next.restore_req = 1'b0;
    st_next.clear_req   = 1'b0;
    st_next.on_prev     = chan_on;

    if (meas_valid) begin
      case (kind)
        pmt_pkg::PMT_MK_POUT: begin
          st_next.pout[meas_chan] = meas_value;
        end
        pmt_pkg::PMT_MK_IOUT: begin
          // 2.5 mA per count, saturating outside the 16-bit range
          st_next.fine[meas_chan]  = sat_fine(meas_iout_fine);
          // count kept raw; select bit only sets the LSB weight
          st_next.sense[meas_chan] = abs_sense(meas_sense);
        end
        default: ;
      endcase
    end

    if (cmd_valid) begin
      st_next.rsp_valid = 1'b1;
      st_next.rsp_data  = 16'h0000;
      // A block read is a run of back-to-back log reads
      if (!(cmd_read && cmd_code == `PMT_CMD_LOG_READ)) begin
        st_next.log_idx = 8'h00;
      end
      if (cmd_read) begin
        case (cmd_code)
          // latest output power of the page
          `PMT_CMD_READ_POUT:  st_next.rsp_data = st_reg.pout[ch];
          `PMT_CMD_FINE_IOUT:  st_next.rsp_data = st_reg.fine[ch];
          `PMT_CMD_SENSE_VOLT: st_next.rsp_data = st_reg.sense[ch];
          `PMT_CMD_VIN_MAX:    st_next.rsp_data = vin_pk;
          `PMT_CMD_VIN_LOW:    st_next.rsp_data = vin_lo;
          `PMT_CMD_VOUT_PEAK:  st_next.rsp_data = vout_pk[ch];
          `PMT_CMD_VOUT_MIN:   st_next.rsp_data = vout_lo[ch];
          `PMT_CMD_IOUT_PEAK:  st_next.rsp_data = iout_pk[ch];
          `PMT_CMD_IOUT_MIN:   st_next.rsp_data = iout_lo[ch];
          `PMT_CMD_TEMP_PEAK:  st_next.rsp_data = temp_pk[ch];
          `PMT_CMD_TEMP_MIN:   st_next.rsp_data = temp_lo[ch];
          `PMT_CMD_LOG_STATUS: begin
            st_next.rsp_data[`PMT_STAT_RAM_BIT] = st_reg.stat_ram;
            st_next.rsp_data[`PMT_STAT_EEP_BIT] = st_reg.stat_eep;
          end
          `PMT_CMD_LOG_READ: begin
            st_next.rsp_data = {8'h00, log_byte};
            if (st_reg.log_idx == LAST_IDX) begin
              st_next.log_idx  = 8'h00;
              st_next.stat_ram = 1'b0;
            end else begin
              st_next.log_idx = st_reg.log_idx + 8'h01;
            end
          end
          default: st_next.rsp_err = 1'b1;
        endcase
        if (!paged_ok && (cmd_code == `PMT_CMD_READ_POUT ||
            cmd_code == `PMT_CMD_FINE_IOUT ||
            cmd_code == `PMT_CMD_SENSE_VOLT)) begin
          st_next.rsp_err = 1'b1;
        end
      end else begin
        case (cmd_code)
          `PMT_CMD_CLEAR_FAULTS: begin
          end
          `PMT_CMD_LOG_STORE:   st_next.store_req = 1'b1;
          `PMT_CMD_LOG_RESTORE: st_next.restore_req = 1'b1;
          `PMT_CMD_LOG_CLEAR: begin
            st_next.clear_req = 1'b1;
            st_next.stat_eep  = 1'b0;
            st_next.stat_ram  = 1'b0;
          end
          default: st_next.rsp_err = 1'b1;
        endcase
      end
    end

    // completed copy sets inhibit, winning over a clear
    if (log_eep_done) begin
      st_next.stat_eep = 1'b1;
    end
    // restored RAM stays locked until fully read or log clear
    if (log_restore_done) begin
      st_next.stat_ram = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg.pout        <= '0;
      st_reg.fine        <= '0;
      st_reg.sense       <= '0;
      st_reg.on_prev     <= 2'h3;
      st_reg.stat_ram    <= 1'b0;
      st_reg.stat_eep    <= 1'b0;
      st_reg.log_idx     <= 8'h00;
      st_reg.rsp_valid   <= 1'b0;
      st_reg.rsp_data    <= 16'h0000;
      st_reg.rsp_err     <= 1'b0;
      st_reg.store_req   <= 1'b0;
      st_reg.restore_req <= 1'b0;
      st_reg.clear_req   <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rsp_valid       = st_reg.rsp_valid;
  assign rsp_data        = st_reg.rsp_data;
  assign rsp_err         = st_reg.rsp_err;
  assign log_store_req   = st_reg.store_req;
  assign log_restore_req = st_reg.restore_req;
  assign log_clear_req   = st_reg.clear_req;
  assign log_byte_idx    = st_reg.log_idx;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  fine_encode_a: assert property (
    meas_valid && kind == pmt_pkg::PMT_MK_IOUT &&
    meas_iout_fine <= 20'sd32767 && meas_iout_fine >= -20'sd32768
    |=> st_reg.fine[$past(meas_chan)] == $past(meas_iout_fine[15:0]))
    else $error("fine current not one count per 2.5 mA");
  fine_clamp_a: assert property (
    meas_valid && kind == pmt_pkg::PMT_MK_IOUT &&
    meas_iout_fine > 20'sd32767
    |=> st_reg.fine[$past(meas_chan)] == `PMT_FINE_MAX)
    else $error("fine current not saturated");
  sense_abs_a: assert property (
    meas_valid && kind == pmt_pkg::PMT_MK_IOUT &&
    meas_sense < 0 && meas_sense > -17'sd65536
    |=> st_reg.sense[$past(meas_chan)] == $past(16'(-meas_sense)))
    else $error("sense voltage not absolute");
  pout_read_a: assert property (
    cmd_valid && cmd_read && cmd_code == `PMT_CMD_READ_POUT
    |=> rsp_valid && rsp_data == $past(st_reg.pout[ch]))
    else $error("power read returned wrong value");
  vin_reinit_a: assert property (
    |on_rise |=> vin_pk == `PMT_VIN_PEAK_INIT &&
                 vin_lo == `PMT_VIN_MIN_INIT)
    else $error("input extremes not reloaded on turn-on");
  store_pulse_a: assert property (
    send_cmd && cmd_code == `PMT_CMD_LOG_STORE ##1
    !(send_cmd && cmd_code == `PMT_CMD_LOG_STORE)
    |-> log_store_req ##1 !log_store_req)
    else $error("store request not a single pulse");
  restore_pulse_a: assert property (
    send_cmd && cmd_code == `PMT_CMD_LOG_RESTORE |=> log_restore_req)
    else $error("restore request missing");
  log_clear_a: assert property (
    send_cmd && cmd_code == `PMT_CMD_LOG_CLEAR && !log_eep_done
    |=> log_clear_req && !st_reg.stat_eep)
    else $error("log clear did not release inhibit");
  log_byte_a: assert property (
    cmd_valid && cmd_read && cmd_code == `PMT_CMD_LOG_READ
    |=> rsp_data == {8'h00, $past(log_byte)})
    else $error("log byte not returned");
  status_read_a: assert property (
    cmd_valid && cmd_read && cmd_code == `PMT_CMD_LOG_STATUS
    |=> rsp_data == {14'h0000, $past(st_reg.stat_ram),
                     $past(st_reg.stat_eep)})
    else $error("status byte wrong");
  eep_hold_a: assert property (
    st_reg.stat_eep && !(send_cmd && cmd_code == `PMT_CMD_LOG_CLEAR) |=>
    st_reg.stat_eep)
    else $error("inhibit bit dropped without log clear");
  eep_set_a: assert property (
    log_eep_done |=> st_reg.stat_eep)
    else $error("inhibit bit not set after copy");

  store_seen_c: cover property (send_cmd && cmd_code == `PMT_CMD_LOG_STORE);
  full_read_c: cover property (
    cmd_valid && cmd_read && cmd_code == `PMT_CMD_LOG_READ &&
    st_reg.log_idx == LAST_IDX && st_reg.stat_ram);
  fine_sat_c: cover property (
    meas_valid && kind == pmt_pkg::PMT_MK_IOUT &&
    meas_iout_fine > 20'sd32767);
  turn_on_c: cover property (|on_rise);

endmodule

// *** testbench/pmt_log_model.sv ***
`timescale 1ns/1ns

module pmt_log_model #(
  parameter int DLY = 3
) (
  input  wire logic       sys_clk,      // System clock
  input  wire logic       rst_b,        // Sync reset, active low
  input  wire logic       store_req,    // Copy RAM to storage
  input  wire logic       restore_req,  // Copy storage to RAM
  input  wire logic       clear_req,    // Erase storage
  input  wire logic [7:0] byte_idx,     // Log byte index
  output logic            eep_done,     // Copy finished
  output logic            restore_done, // Restore finished
  output logic      [7:0] log_byte      // Byte at index
);
  int st_cnt = 0;
  int rs_cnt = 0;

  assign log_byte = byte_idx ^ 8'h5a;

  always @(posedge sys_clk) begin
    eep_done <= rst_b && st_cnt == 1;
    restore_done <= rst_b && rs_cnt == 1;
    if (!rst_b || clear_req) begin
      st_cnt <= 0;
      rs_cnt <= 0;
    end else begin
      st_cnt <= store_req ? DLY : (st_cnt > 0 ? st_cnt - 1 : 0);
      rs_cnt <= restore_req ? DLY : (rs_cnt > 0 ? rs_cnt - 1 : 0);
    end
  end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ns

module tb;
  localparam int NB = 4;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               cmd_valid = 1'b0;
  logic        [7:0]  cmd_code = 8'h00;
  logic        [7:0]  cmd_page = 8'h00;
  logic               cmd_read = 1'b0;
  logic               meas_valid = 1'b0;
  logic        [4:0]  meas_kind = 5'h01;
  logic               meas_chan = 1'b0;
  logic        [15:0] meas_value = 16'h0000;
  logic signed [19:0] meas_iout_fine = 20'h00000;
  logic signed [16:0] meas_sense = 17'h00000;
  logic        [1:0]  chan_on = 2'h0;
  logic               eep_done, restore_done, rsp_valid, rsp_err;
  logic               st_req, rs_req, cl_req;
  logic        [7:0]  log_byte, byte_idx;
  logic        [15:0] rsp_data;
  int                 fails = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  logic        [7:0]  codes [8] = '{8'hde, 8'hfc, 8'hdd, 8'hfb,
                                    8'hd7, 8'hd8, 8'hdf, 8'hfd};
  logic        [15:0] inits [8] = '{16'h7c00, 16'h7bff, 16'hf800,
    16'hffff, 16'h7c00, 16'h7bff, 16'h7c00, 16'h7bff};

  pmt_telemetry #(.LOG_BYTES(NB)) pmt_telemetry_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_read(cmd_read),
    .meas_valid(meas_valid), .meas_kind(meas_kind),
    .meas_chan(meas_chan), .meas_value(meas_value),
    .meas_iout_fine(meas_iout_fine), .meas_sense(meas_sense),
    .chan_on(chan_on), .log_eep_done(eep_done),
    .log_restore_done(restore_done), .log_byte(log_byte),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .log_store_req(st_req), .log_restore_req(rs_req),
    .log_clear_req(cl_req), .log_byte_idx(byte_idx));

  pmt_log_model pmt_log_model_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .store_req(st_req),
    .restore_req(rs_req), .clear_req(cl_req), .byte_idx(byte_idx),
    .eep_done(eep_done), .restore_done(restore_done),
    .log_byte(log_byte));

  always #25 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, whole run is about 165 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flags are {valid, err, store, restore, clear}
  task automatic cmd(input logic [7:0] c, input logic [7:0] p,
                     input logic r, input logic [4:0] f);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_page <= p;
    cmd_read <= r;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(negedge sys_clk);
    chk({11'h0, rsp_valid, rsp_err, st_req, rs_req, cl_req}, 16'(f));
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] p,
                    input logic [15:0] e);
    cmd(c, p, 1'b1, 5'h10);
    chk(rsp_data, e);
  endtask

  task automatic meas(input logic [4:0] k, input logic ch,
                      input logic [15:0] v, input logic signed [19:0] f,
                      input logic signed [16:0] s);
    @(posedge sys_clk);
    meas_valid <= 1'b1;
    meas_kind <= k;
    meas_chan <= ch;
    meas_value <= v;
    meas_iout_fine <= f;
    meas_sense <= s;
    @(posedge sys_clk);
    meas_valid <= 1'b0;
  endtask

  task automatic all_init(input logic [7:0] p);
    for (int i = 0; i < 8; i++) begin
      rd(codes[i], p, inits[i]);
    end
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    all_init(8'h00);
    all_init(8'h01);
    meas(5'h01, 1'b0, 16'h0001, 0, 0);
    meas(5'h01, 1'b1, 16'h0005, 0, 0);
    meas(5'h02, 1'b0, 16'h1000, 0, 0);
    meas(5'h02, 1'b0, 16'h0800, 0, 0);
    meas(5'h04, 1'b1, 16'h0003, 4, 5);
    meas(5'h08, 1'b1, 16'h0002, 0, 0);
    rd(8'hde, 8'h01, 16'h0005);
    rd(8'hfc, 8'h00, 16'h0001);
    rd(8'hdd, 8'h00, 16'h1000);
    rd(8'hfb, 8'h00, 16'h0800);
    rd(8'hdd, 8'h01, 16'hf800);
    rd(8'hd8, 8'h01, 16'h0003);
    rd(8'hdf, 8'h01, 16'h0002);
    cmd(8'h03, 8'h00, 1'b0, 5'h10);
    rd(8'hdd, 8'h00, 16'hf800);
    rd(8'hfb, 8'h00, 16'hffff);
    rd(8'hde, 8'h00, 16'h7c00);
    rd(8'hfc, 8'h01, 16'h7bff);
    rd(8'hd7, 8'h01, 16'h0003);
    @(posedge sys_clk);
    chan_on <= 2'b10;
    all_init(8'h01);
    meas(5'h04, 1'b0, 16'h0001, 20'sd40000, 0);
    rd(8'hbb, 8'h00, 16'h7fff);
    meas(5'h04, 1'b0, 16'h0001, -20'sd40000, -17'sd65536);
    rd(8'hbb, 8'h00, 16'h8000);
    rd(8'hfa, 8'h00, 16'hffff);
    meas(5'h04, 1'b0, 16'h0001, -20'sd3, -17'sd506);
    rd(8'hbb, 8'h00, 16'hfffd);
    rd(8'hfa, 8'h00, 16'h01fa);
    meas(5'h10, 1'b1, 16'h1234, 0, 0);
    rd(8'h96, 8'h01, 16'h1234);
    meas(5'h02, 1'b1, 16'h2000, 0, 0);
    rd(8'hdd, 8'h01, 16'h2000);
    cmd(8'h03, 8'hff, 1'b0, 5'h10);
    rd(8'hdd, 8'h01, 16'hf800);
    cmd(8'h00, 8'h00, 1'b1, 5'h18);
    cmd(8'h96, 8'h02, 1'b1, 5'h18);
    cmd(8'hea, 8'h00, 1'b0, 5'h14);
    repeat (8) @(posedge sys_clk);
    rd(8'hed, 8'h00, 16'h0001);
    cmd(8'heb, 8'h01, 1'b0, 5'h12);
    repeat (8) @(posedge sys_clk);
    rd(8'hed, 8'h00, 16'h0003);
    for (int i = 0; i < NB; i++) begin
      rd(8'hee, 8'h00, {8'h00, 8'(i) ^ 8'h5a});
    end
    rd(8'hed, 8'h00, 16'h0001);
    cmd(8'hec, 8'h00, 1'b0, 5'h11);
    rd(8'hed, 8'h00, 16'h0000);
    complete_run();
  end
endmodule
